// ==== design/host_port_pkg.sv ====
package host_port_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 40;
    localparam int HALF_CYCLE_NS    = CLK_PERIOD_NS / 2;
    localparam int EXTRA_NS         = 16;
    localparam int WAIT_DMA16_NS    = 18 * HALF_CYCLE_NS + EXTRA_NS;
    localparam int WAIT_DMA32_NS    = 26 * HALF_CYCLE_NS + EXTRA_NS;
    localparam int WAIT_IDLE_NS     = 10 * HALF_CYCLE_NS + EXTRA_NS;
    localparam int WAIT_INTBIT_NS   = 6 * HALF_CYCLE_NS + EXTRA_NS;
    // Longest times round down, never below one cycle
    localparam int WAIT_DMA16_CYC   = (WAIT_DMA16_NS / CLK_PERIOD_NS) < 1 ? 1 : WAIT_DMA16_NS / CLK_PERIOD_NS;
    localparam int WAIT_DMA32_CYC   = (WAIT_DMA32_NS / CLK_PERIOD_NS) < 1 ? 1 : WAIT_DMA32_NS / CLK_PERIOD_NS;
    localparam int WAIT_IDLE_CYC    = (WAIT_IDLE_NS / CLK_PERIOD_NS) < 1 ? 1 : WAIT_IDLE_NS / CLK_PERIOD_NS;
    localparam int WAIT_INTBIT_CYC  = (WAIT_INTBIT_NS / CLK_PERIOD_NS) < 1 ? 1 : WAIT_INTBIT_NS / CLK_PERIOD_NS;
    localparam int CNT_W            = 4;

    // ------------------------------------------------------------
    // Access types and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] ACC_CONTROL = 2'h0;
    localparam logic [7:0] DATA_RESET  = 8'h00;
    localparam logic [3:0] CNT_RESET   = 4'h0;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_FETCH = 3'b010,
        ST_WAIT  = 3'b100
    } port_state_type;
endpackage : host_port_pkg

// ==== design/pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_ce,
    input  wire logic [WIDTH-1:0] i_async,
    input  wire logic [WIDTH-1:0] i_reset_val,
    output var  logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] next_sync;

    // A change counts only once the second and third stages agree
    always_comb begin
        next_sync = o_sync;
        for (int k = 0; k < WIDTH; k++) begin
            if (s2[k] == s3[k]) begin
                next_sync[k] = s3[k];
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            s1     <= '0;
            s2     <= '0;
            s3     <= '0;
            o_sync <= '0;
        end else if (i_ce) begin
            s1     <= i_async;
            s2     <= s1;
            s3     <= s2;
            o_sync <= next_sync;
        end
    end
    // Reset value port unused: reset loads zeros, so idle-high pins are inverted by the caller
    logic unused_ok;
    assign unused_ok = ^i_reset_val;
endmodule : pin_sync
`default_nettype wire

// ==== design/host_port_handshake.sv ====
// Notes on behaviour
// - Access active only while select and strobes low
// - Ready high whenever port select high
// - Read data driven only after strobe falls
// - First byte immediate; second byte waits fetch
// - Memory wait bounded by DMA mode
// - Interrupt-bit control writes drop ready briefly
// - Other control writes keep ready high
// - Ready rises on CPU clock edge
// - Host interrupt changes on CPU clock edge
// - Memory access stretched while DMA uses bus
// - Control bits latched on address or access strobe
// - General-purpose pins updated and sampled on clock
`timescale 1ns/1ps
`default_nettype none
module host_port_handshake (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_ce,
    // Host pins
    input  wire logic       i_port_select_n,
    input  wire logic       i_data_strobe_a_n,
    input  wire logic       i_data_strobe_b_n,
    input  wire logic       i_address_strobe_n,
    input  wire logic       i_access_type_bit0,
    input  wire logic       i_access_type_bit1,
    input  wire logic       i_read_write_select,
    input  wire logic       i_byte_ident_input,
    input  wire logic [7:0] i_host_data_bus,
    output logic      [7:0] o_host_data_bus,
    output logic            o_host_data_bus_oe,
    output logic            o_host_ready_out,
    output logic            o_host_interrupt_out,
    // Internal side
    input  wire logic       i_gpio_mode,
    input  wire logic [7:0] i_gpio_dir,
    input  wire logic [7:0] i_gpio_out,
    output logic      [7:0] o_gpio_in,
    input  wire logic       i_host_interrupt_set,
    input  wire logic       i_host_interrupt_clear,
    input  wire logic       i_dma_active,
    input  wire logic       i_dma_32bit,
    input  wire logic       i_dma_bus_busy,
    input  wire logic [7:0] i_ctrl_read_byte,
    output logic            o_mem_req,
    output logic            o_mem_write,
    input  wire logic       i_mem_ack,
    input  wire logic [15:0] i_mem_rdata,
    output logic      [15:0] o_mem_wdata,
    output logic      [1:0] o_access_type,
    output logic            o_ctrl_write,
    output logic      [7:0] o_ctrl_wdata,
    output logic            o_ctrl_byte_ident,
    output logic            o_dsp_interrupt_request_bit
);
    import host_port_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [15:0] pins_sync;
    logic        sel_n_s;
    logic        strobe_a_s;
    logic        strobe_b_s;
    logic        addr_strobe_s;
    logic [3:0]  ctl_s;
    logic [7:0]  data_s;

    pin_sync #(.WIDTH(16)) u_pin_sync (
        .i_sys_clk   (i_sys_clk),
        .i_rst_n     (i_rst_n),
        .i_ce        (i_ce),
        .i_async     ({~i_port_select_n, ~i_data_strobe_a_n, ~i_data_strobe_b_n, ~i_address_strobe_n,
                       i_access_type_bit1, i_access_type_bit0, i_read_write_select, i_byte_ident_input,
                       i_host_data_bus}),
        .i_reset_val (16'h0000),
        .o_sync      (pins_sync)
    );
    // Strobes enter inverted so that reset zeros mean idle
    assign sel_n_s       = ~pins_sync[15];
    assign strobe_a_s    = ~pins_sync[14];
    assign strobe_b_s    = ~pins_sync[13];
    assign addr_strobe_s = ~pins_sync[12];
    assign ctl_s         = pins_sync[11:8];
    assign data_s        = pins_sync[7:0];

    logic combined_access_strobe;
    assign combined_access_strobe = sel_n_s | strobe_a_s | strobe_b_s;

    // ------------------------------------------------------------
    // Handshake state
    // ------------------------------------------------------------
    port_state_type state;
    port_state_type next_state;
    logic           strobe_q;
    logic           addr_q;
    logic [3:0]     latched_control_group;
    logic [3:0]     next_latched_control_group;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [15:0]    word;
    logic [15:0]    next_word;
    logic [7:0]     wbyte;
    logic [7:0]     next_wbyte;
    logic           next_ready;
    logic           next_oe;
    logic [7:0]     next_hd;
    logic           next_int;
    logic [7:0]     next_gpio_in;
    logic           next_req;
    logic           next_mwr;
    logic           next_cwr;
    logic           next_dsp_interrupt_request_bit;

    logic strobe_fall;
    logic strobe_rise;
    logic addr_fall;
    logic is_read;
    logic is_mem;
    logic intbit_write;
    logic [CNT_W-1:0] mem_limit;

    assign strobe_fall = strobe_q & ~combined_access_strobe;
    assign strobe_rise = ~strobe_q & combined_access_strobe;
    assign addr_fall   = addr_q & ~addr_strobe_s;
    assign is_read     = latched_control_group[1];
    assign is_mem      = latched_control_group[3:2] != ACC_CONTROL;
    assign intbit_write = ~is_read & ~is_mem & (data_s[1] | data_s[3]);

    always_comb begin
        if (!i_dma_active) begin
            mem_limit = CNT_W'(WAIT_IDLE_CYC);
        end else if (i_dma_32bit) begin
            mem_limit = CNT_W'(WAIT_DMA32_CYC);
        end else begin
            mem_limit = CNT_W'(WAIT_DMA16_CYC);
        end
    end

    always_comb begin
        next_state   = state;
        next_cnt     = cnt;
        next_word    = word;
        next_wbyte   = wbyte;
        next_ready   = o_host_ready_out;
        next_oe      = o_host_data_bus_oe;
        next_hd      = o_host_data_bus;
        next_req     = 1'b0;
        next_mwr     = o_mem_write;
        next_cwr     = 1'b0;
        next_dsp_interrupt_request_bit  = 1'b0;
        next_latched_control_group = latched_control_group;
        next_int     = o_host_interrupt_out;
        next_gpio_in = o_gpio_in;

        if (addr_fall) begin
            next_latched_control_group = ctl_s;
        end else if (strobe_fall && addr_strobe_s) begin
            next_latched_control_group = ctl_s;
        end

        unique case (state)
            ST_IDLE: begin
                if (!i_gpio_mode && strobe_fall && next_latched_control_group[1]) begin
                    next_oe = 1'b1;
                    if (next_latched_control_group[3:2] == ACC_CONTROL) begin
                        next_hd = i_ctrl_read_byte;
                    end else if (next_latched_control_group[0]) begin
                        next_hd = word[7:0];
                    end else begin
                        next_hd = word[15:8];
                    end
                end
                if (!i_gpio_mode && strobe_fall && !next_latched_control_group[1]) begin
                    next_oe = 1'b0;
                end
                if (strobe_rise) begin
                    next_oe = 1'b0;
                    if (is_mem && latched_control_group[0]) begin
                        // Read prefetches after the second byte, write commits after it
                        next_ready = 1'b0;
                        next_cnt   = CNT_RESET;
                        next_req   = 1'b1;
                        next_mwr   = ~is_read;
                        next_state = ST_FETCH;
                    end else if (!is_mem && !is_read) begin
                        next_cwr    = 1'b1;
                        next_dsp_interrupt_request_bit = data_s[1];
                        if (intbit_write) begin
                            next_ready = 1'b0;
                            next_cnt   = CNT_W'(WAIT_INTBIT_CYC);
                            next_state = ST_WAIT;
                        end
                    end
                    if (!is_read && !latched_control_group[0]) begin
                        next_wbyte = data_s;
                    end
                end
            end
            ST_FETCH: begin
                next_cnt = cnt + 1'b1;
                if (i_dma_bus_busy) begin
                    next_req = 1'b1;
                end else if (i_mem_ack || cnt >= mem_limit - 1'b1) begin
                    if (!o_mem_write) begin
                        next_word = i_mem_rdata;
                    end
                    next_ready = 1'b1;
                    next_state = ST_IDLE;
                end else begin
                    next_req = 1'b1;
                end
            end
            ST_WAIT: begin
                next_cnt = cnt - 1'b1;
                if (cnt <= 4'h1) begin
                    next_ready = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_ready = 1'b1;
            end
        endcase

        if (sel_n_s) begin
            next_ready = 1'b1;
        end

        if (i_gpio_mode) begin
            next_oe      = |i_gpio_dir;
            next_hd      = i_gpio_out & i_gpio_dir;
            next_gpio_in = data_s;
        end

        if (i_host_interrupt_set) begin
            next_int = 1'b1;
        end else if (i_host_interrupt_clear) begin
            next_int = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            state                 <= ST_IDLE;
            strobe_q              <= 1'b1;
            addr_q                <= 1'b1;
            latched_control_group <= 4'h0;
            cnt                   <= CNT_RESET;
            word                  <= 16'h0000;
            wbyte                 <= DATA_RESET;
            o_host_ready_out      <= 1'b1;
            o_host_data_bus_oe    <= 1'b0;
            o_host_data_bus       <= DATA_RESET;
            o_host_interrupt_out  <= 1'b0;
            o_gpio_in             <= DATA_RESET;
            o_mem_req             <= 1'b0;
            o_mem_write           <= 1'b0;
            o_ctrl_write          <= 1'b0;
            o_dsp_interrupt_request_bit <= 1'b0;
        end else if (i_ce) begin
            state                 <= next_state;
            strobe_q              <= combined_access_strobe;
            addr_q                <= addr_strobe_s;
            latched_control_group <= next_latched_control_group;
            cnt                   <= next_cnt;
            word                  <= next_word;
            wbyte                 <= next_wbyte;
            o_host_ready_out      <= next_ready;
            o_host_data_bus_oe    <= next_oe;
            o_host_data_bus       <= next_hd;
            o_host_interrupt_out  <= next_int;
            o_gpio_in             <= next_gpio_in;
            o_mem_req             <= next_req;
            o_mem_write           <= next_mwr;
            o_ctrl_write          <= next_cwr;
            o_dsp_interrupt_request_bit <= next_dsp_interrupt_request_bit;
        end
    end

    // Write data held from the closing write strobe, so a slow memory sees it steady
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_mem_wdata       <= 16'h0000;
            o_access_type     <= 2'h0;
            o_ctrl_wdata      <= DATA_RESET;
            o_ctrl_byte_ident <= 1'b0;
        end else if (i_ce) begin
            o_mem_wdata       <= (strobe_rise && !is_read) ? {wbyte, data_s} : o_mem_wdata;
            o_access_type     <= latched_control_group[3:2];
            o_ctrl_wdata      <= (strobe_rise && !is_read) ? data_s : o_ctrl_wdata;
            o_ctrl_byte_ident <= latched_control_group[0];
        end
    end
endmodule : host_port_handshake
`default_nettype wire

// ==== bench/host_port_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_port_properties (
    input wire logic       i_sys_clk,
    input wire logic       i_rst_n,
    input wire logic       i_port_select_n,
    input wire logic       i_data_strobe_a_n,
    input wire logic       i_data_strobe_b_n,
    input wire logic       i_gpio_mode,
    input wire logic       i_host_interrupt_set,
    input wire logic       i_dma_bus_busy,
    input wire logic       o_host_data_bus_oe,
    input wire logic       o_host_ready_out,
    input wire logic       o_host_interrupt_out,
    input wire logic       o_mem_req,
    input wire logic       o_ctrl_write,
    input wire logic [7:0] o_ctrl_wdata
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    wire logic strobe_hi = i_port_select_n | i_data_strobe_a_n | i_data_strobe_b_n;
    // Interrupt-bit write: ready drops, then comes back quickly
    sequence rdy_drop_s; ##[0:3] !o_host_ready_out; endsequence
    sequence rdy_back_s; ##[1:4] o_host_ready_out; endsequence
    sel_ready_a: assert property (i_port_select_n [*6] |-> o_host_ready_out)
        else $error("ready low while deselected");
    oe_cause_a: assert property ($rose(o_host_data_bus_oe) && !i_gpio_mode |-> !strobe_hi)
        else $error("bus driven without access");
    oe_release_a: assert property (!i_gpio_mode throughout strobe_hi [*8] |-> !o_host_data_bus_oe)
        else $error("bus still driven after strobe");
    wait_bound_a: assert property ($fell(o_host_ready_out) && !i_dma_bus_busy |-> ##[1:15] o_host_ready_out)
        else $error("ready wait too long");
    dma_stretch_a: assert property (i_dma_bus_busy && o_mem_req && !o_host_ready_out
                                    |=> !o_host_ready_out || $past(i_port_select_n, 5))
        else $error("ready rose while bus busy");
    intbit_wait_a: assert property (o_ctrl_write && (o_ctrl_wdata[1] || o_ctrl_wdata[3]) |-> rdy_drop_s ##0 rdy_back_s)
        else $error("interrupt-bit write wait wrong");
    plain_ctrl_a: assert property (o_ctrl_write && !o_ctrl_wdata[1] && !o_ctrl_wdata[3] |-> o_host_ready_out [*4])
        else $error("plain control write dropped ready");
    host_interrupt_out_cause_a: assert property ($rose(o_host_interrupt_out) |-> $past(i_host_interrupt_set) || $past(i_host_interrupt_set, 2))
        else $error("interrupt rose without set");
endmodule : host_port_properties
bind host_port_handshake host_port_properties u_host_port_properties (.i_sys_clk, .i_rst_n, .i_port_select_n,
    .i_data_strobe_a_n, .i_data_strobe_b_n, .i_gpio_mode, .i_host_interrupt_set, .i_dma_bus_busy,
    .o_host_data_bus_oe, .o_host_ready_out, .o_host_interrupt_out, .o_mem_req, .o_ctrl_write, .o_ctrl_wdata);
`default_nettype wire

// ==== bench/mem_responder.sv ====
`timescale 1ns/1ps
`default_nettype none
module mem_responder (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    input  wire logic [3:0]  i_delay,
    input  wire logic        i_mem_req,
    input  wire logic        i_mem_write,
    input  wire logic [15:0] i_mem_wdata,
    output logic             o_mem_ack,
    output logic      [15:0] o_mem_rdata,
    output logic      [15:0] o_word
);
    logic [3:0] wait_cnt;
    always_ff @(posedge i_sys_clk) begin
        o_mem_ack <= 1'b0;
        // Stale data toggles so it is never mistaken for a fetch
        o_mem_rdata <= ~o_mem_rdata;
        if (!i_rst_n) begin
            wait_cnt <= 4'h0;
            o_word <= 16'h0000;
            o_mem_rdata <= 16'h0000;
        end else if (!i_mem_req) begin
            wait_cnt <= 4'h0;
        end else if (!o_mem_ack) begin
            wait_cnt <= wait_cnt + 4'h1;
            if (wait_cnt >= i_delay) begin
                o_mem_ack <= 1'b1;
                wait_cnt <= 4'h0;
                if (i_mem_write) o_word <= i_mem_wdata;
                else o_mem_rdata <= o_word;
            end
        end
    end
endmodule : mem_responder
`default_nettype wire

// ==== bench/host_port_handshake_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_port_handshake_bench;
    import host_port_pkg::*;
    logic i_sys_clk, i_rst_n, i_ce, i_port_select_n, i_data_strobe_a_n, i_data_strobe_b_n, i_address_strobe_n;
    logic i_access_type_bit0, i_access_type_bit1, i_read_write_select, i_byte_ident_input, o_host_data_bus_oe;
    logic o_host_ready_out, o_host_interrupt_out, i_gpio_mode, i_host_interrupt_set, i_host_interrupt_clear;
    logic i_dma_active, i_dma_32bit, i_dma_bus_busy, o_mem_req, o_mem_write, i_mem_ack, o_ctrl_write;
    logic o_ctrl_byte_ident, o_dsp_interrupt_request_bit, dsp_seen;
    logic [7:0] o_host_data_bus, i_gpio_dir, i_gpio_out, o_gpio_in, i_ctrl_read_byte, o_ctrl_wdata, host_drive, rd;
    logic [15:0] i_mem_rdata, o_mem_wdata, word;
    logic [1:0] o_access_type;
    logic [3:0] mem_delay;
    int low, bnd, mismatches, checks_done;
    // Pin level: the port wins while it drives, else the host
    wire logic [7:0] i_host_data_bus = o_host_data_bus_oe ? o_host_data_bus : host_drive;
    host_port_handshake u_host_port_handshake (.i_sys_clk, .i_rst_n, .i_ce, .i_port_select_n, .i_data_strobe_a_n,
        .i_data_strobe_b_n, .i_address_strobe_n, .i_access_type_bit0, .i_access_type_bit1, .i_read_write_select,
        .i_byte_ident_input, .i_host_data_bus, .o_host_data_bus, .o_host_data_bus_oe, .o_host_ready_out,
        .o_host_interrupt_out, .i_gpio_mode, .i_gpio_dir, .i_gpio_out, .o_gpio_in, .i_host_interrupt_set,
        .i_host_interrupt_clear, .i_dma_active, .i_dma_32bit, .i_dma_bus_busy, .i_ctrl_read_byte, .o_mem_req,
        .o_mem_write, .i_mem_ack, .i_mem_rdata, .o_mem_wdata, .o_access_type, .o_ctrl_write, .o_ctrl_wdata,
        .o_ctrl_byte_ident, .o_dsp_interrupt_request_bit);
    mem_responder u_mem_responder (.i_sys_clk, .i_rst_n, .i_delay(mem_delay), .i_mem_req(o_mem_req),
        .i_mem_write(o_mem_write), .i_mem_wdata(o_mem_wdata), .o_mem_ack(i_mem_ack), .o_mem_rdata(i_mem_rdata),
        .o_word(word));
    initial begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) if (o_dsp_interrupt_request_bit === 1'b1) dsp_seen = 1'b1;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask : tick
    task automatic test_done;
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    // ----------------------------------------
    // One host byte; ready is counted while still selected
    // ----------------------------------------
    task automatic xfer(input logic [1:0] at, input logic r, input logic b, input logic use_as, input logic [7:0] wd);
        {i_access_type_bit1, i_access_type_bit0} = at;
        i_read_write_select = r;
        i_byte_ident_input = b;
        host_drive = wd;
        tick(1);
        if (use_as) begin
            i_address_strobe_n = 1'b0;
            tick(1);
        end
        i_port_select_n = 1'b0;
        if (b) i_data_strobe_b_n = 1'b0;
        else i_data_strobe_a_n = 1'b0;
        tick(1);
        {i_data_strobe_a_n, i_data_strobe_b_n} = 2'b00;
        tick(8);
        rd = o_host_data_bus;
        {i_address_strobe_n, i_data_strobe_a_n, i_data_strobe_b_n} = 3'b111;
        tick(1);
        host_drive = ~wd;
        low = 0;
        repeat (40) begin
            tick(1);
            if (o_host_ready_out !== 1'b1) low++;
        end
        i_port_select_n = 1'b1;
        tick(2);
    endtask : xfer
    initial begin
        #(40 * 6000);
        mismatches++;
        test_done;
    end
    initial begin
        {i_rst_n, i_ce, i_gpio_mode, i_host_interrupt_set, i_host_interrupt_clear, dsp_seen} = 6'b010000;
        {i_port_select_n, i_data_strobe_a_n, i_data_strobe_b_n, i_address_strobe_n} = 4'hf;
        {i_access_type_bit0, i_access_type_bit1, i_read_write_select, i_byte_ident_input} = 4'h0;
        {i_dma_active, i_dma_32bit, i_dma_bus_busy} = 3'b000;
        {i_gpio_dir, i_gpio_out, i_ctrl_read_byte, host_drive} = {8'h00, 8'h00, 8'hc3, 8'h00};
        {mismatches, checks_done, mem_delay} = {32'h0, 32'h0, 4'h3};
        tick(20);
        i_rst_n = 1'b1;
        chk({o_host_ready_out, o_host_data_bus_oe, o_host_interrupt_out}, 16'h4);
        tick(5);
        i_data_strobe_a_n = 1'b0;
        tick(10);
        chk({o_host_ready_out, o_host_data_bus_oe}, 16'h2);
        i_data_strobe_a_n = 1'b1;
        xfer(2'h0, 1'b0, 1'b0, 1'b1, 8'h05);
        chk(16'(low), 16'h0);
        chk({5'h00, o_ctrl_byte_ident, o_access_type, o_ctrl_wdata}, 16'h0005);
        for (int k = 0; k < 2; k++) begin
            dsp_seen = 1'b0;
            xfer(2'h0, 1'b0, 1'b0, 1'b0, (k == 0) ? 8'h02 : 8'h08);
            chk(16'(low >= 1 && low <= WAIT_INTBIT_CYC), 16'h1);
            chk(16'(dsp_seen), (k == 0) ? 16'h1 : 16'h0);
        end
        xfer(2'h0, 1'b1, 1'b0, 1'b0, 8'h00);
        chk({8'h00, rd}, 16'h00c3);
        chk(16'(o_host_data_bus_oe), 16'h0);
        for (int m = 0; m < 3; m++) begin
            {i_dma_active, i_dma_32bit} = {m != 0, m == 2};
            bnd = (m == 0) ? WAIT_IDLE_CYC : (m == 1) ? WAIT_DMA16_CYC : WAIT_DMA32_CYC;
            xfer(2'h1, 1'b0, 1'b0, 1'b0, 8'h3c);
            chk(16'(low), 16'h0);
            xfer(2'h1, 1'b0, 1'b1, 1'b1, 8'h50 + 8'(m));
            chk(16'(low >= 1 && low <= bnd), 16'h1);
            chk(word, {8'h3c, 8'h50 + 8'(m)});
        end
        for (int p = 0; p < 4; p++) begin
            xfer(2'h1, 1'b1, p[0], 1'b0, 8'h00);
            if (p == 0) chk(16'(low), 16'h0);
            if (p >= 2) chk({8'h00, rd}, p[0] ? 16'h0052 : 16'h003c);
        end
        {i_dma_active, i_dma_32bit, mem_delay} = {2'b00, 4'hf};
        xfer(2'h1, 1'b0, 1'b1, 1'b0, 8'h77);
        chk(16'(low >= 1 && low <= WAIT_IDLE_CYC), 16'h1);
        {i_dma_bus_busy, mem_delay} = {1'b1, 4'h3};
        xfer(2'h1, 1'b0, 1'b1, 1'b0, 8'h66);
        chk(16'(low > WAIT_DMA32_CYC), 16'h1);
        i_dma_bus_busy = 1'b0;
        tick(20);
        chk(16'(o_host_ready_out), 16'h1);
        i_host_interrupt_set = 1'b1;
        tick(1);
        i_host_interrupt_set = 1'b0;
        tick(3);
        chk(16'(o_host_interrupt_out), 16'h1);
        i_host_interrupt_clear = 1'b1;
        tick(1);
        i_host_interrupt_clear = 1'b0;
        tick(3);
        chk(16'(o_host_interrupt_out), 16'h0);
        {i_gpio_mode, host_drive} = {1'b1, 8'h96};
        tick(6);
        chk({8'h00, o_gpio_in}, 16'h0096);
        {i_gpio_dir, i_gpio_out} = {8'hff, 8'h5a};
        tick(8);
        chk({7'h00, o_host_data_bus_oe, o_gpio_in}, 16'h015a);
        test_done;
    end
endmodule : host_port_handshake_bench
`default_nettype wire
